// ### inc/cts_pkg.sv
// Constants for the charge timer supervisor: time base, intervals, field codes.
// Assumes a 125 MHz system clock; analog comparator results arrive as levels.
package cts_pkg;
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned TICK_US         = 1;     // Time base resolution, us
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned SAFETY_MIN      = 15;
  localparam int unsigned WDOG_S          = 32;
  localparam int unsigned DEGLITCH_MS     = 32;
  localparam int unsigned DETECT_MS       = 262;
  localparam int unsigned EOC_DELAY_MS    = 40;
  localparam int unsigned FAULT_PULSE_US  = 128;
  localparam int unsigned SAFETY_TICKS    = SAFETY_MIN * 60 * 1000000 / TICK_US;
  localparam int unsigned WDOG_TICKS      = WDOG_S * 1000000 / TICK_US;
  localparam int unsigned DEGLITCH_TICKS  = DEGLITCH_MS * 1000 / TICK_US;
  localparam int unsigned DETECT_TICKS    = DETECT_MS * 1000 / TICK_US;
  localparam int unsigned EOC_TICKS       = EOC_DELAY_MS * 1000 / TICK_US;
  localparam int unsigned PULSE_TICKS     = FAULT_PULSE_US / TICK_US;
  localparam int unsigned TW              = 30;    // Interval counter width
  // Status state field codes
  localparam logic [1:0]  STATE_READY     = 2'h0;
  localparam logic [1:0]  STATE_CHARGING  = 2'h1;
  localparam logic [1:0]  STATE_DONE      = 2'h2;
  localparam logic [1:0]  STATE_FAULT     = 2'h3;
  localparam logic [2:0]  FAULT_NONE      = 3'h0;
  localparam logic [2:0]  FAULT_TIMER     = 3'h6;
  // Input current limit codes
  localparam logic [1:0]  ILIM_100MA      = 2'h0;
  localparam logic [1:0]  ILIM_500MA      = 2'h1;
  // Regulation voltage code: 3.5 V + 20 mV steps, 3.54 V default
  localparam logic [5:0]  VREG_DEFAULT    = 6'h02;
  localparam logic [5:0]  VREG_MAX        = 6'h2f; // 4.44 V
  typedef enum logic [5:0] {
    PH_IDLE   = 6'b000001,
    PH_SHORT  = 6'b000010,
    PH_FAST   = 6'b000100,
    PH_TAPER  = 6'b001000,
    PH_DETECT = 6'b010000,
    PH_DONE   = 6'b100000
  } cts_phase_type;
endpackage

// ### logic/cts_interval.sv
// Interval counter on the shared tick: holds while frozen, restarts from zero.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cts_interval #(
  parameter int unsigned W = 30
) (
  input  wire logic         clk,     // System clock
  input  wire logic         srst,    // Sync reset
  input  wire logic         tick,    // Time base enable
  input  wire logic         run,     // Count while high
  input  wire logic         freeze,  // Hold value
  input  wire logic         restart, // Back to zero
  input  wire logic [W-1:0] limit,   // Terminal count
  output logic              expired  // Reached limit, registered
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         exp_q, exp_d;
  always_comb
  begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (restart || !run)
    begin
      cnt_d = '0;            // [RULE21]
      exp_d = 1'b0;
    end
    else if (tick && !freeze && !exp_q)
    begin
      cnt_d = cnt_q + W'(1);
      if (cnt_q + W'(1) >= limit)
        exp_d = 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign expired = exp_q;
  a_freeze_holds: assert property (@(posedge clk) disable iff (srst)
    (run && !restart && freeze) |=> (cnt_q == $past(cnt_q))) else $error("count moved while frozen"); // [RULE21]
endmodule // cts_interval
`default_nettype wire

// ### logic/cts_supervisor.sv
// Charge timer supervisor: safety timer, host watchdog, phases, termination.
// Assumes host write strobes come from a register block on clk; analog flags and
// host_role_pin are asynchronous levels and are synchronised here.
// Functional notes
// RULE1: Good adapter and battery start 15-minute timer; any host write disables it.
// RULE2: Disabling the 15-minute timer starts the 32-second watchdog.
// RULE3: Writing restart bit restarts watchdog; bit clears itself afterwards.
// RULE4: Watchdog expiry ends charge, restores defaults, resumes in 15-minute mode.
// RULE5: 15-minute expiry stops charge, sets fault state, emits 128 us pulse.
// RULE6: Timer fault cleared only by power-on reset; status held until read.
// RULE7: At power-on use programmed bits if watchdog was alive, else defaults. Here only host mode is kept; the programmed fields reset to defaults.
// RULE8: In 15-minute mode above low-voltage threshold, stay high impedance.
// RULE9: Current limit from host-role pin in 15-minute mode, programmed in host mode.
// RULE10: Low-side switch synchronous only above 100 mA, else off.
// RULE11: Short current below short threshold, fast current to regulation, then taper.
// RULE12: Regulation voltage programmable 3.5 to 4.44 V in host mode, else 3.54 V.
// RULE13: With termination, 32 ms deglitch plus term current starts 262 ms detect.
// RULE14: Battery still high after detect means done; status 40 ms later.
// RULE15: Termination enable at zero means termination routine is never entered.
// RULE16: New cycle on recharge fall, POR with low battery, enable toggle, reset bit.
// RULE17: Above thermal regulation threshold, taper current towards zero.
// RULE18: Thermal shutdown suspends charge, PWM off, freezes timers until cooled.
// RULE19: Charge-enable bit is active low.
// RULE20: Reset bit restores defaults except safety limits, then self-clears.
// RULE21: All intervals from one time base; counters hold frozen, restart at zero.
`timescale 1ns/100ps
`default_nettype none
module cts_supervisor #(
  parameter int unsigned SAFETY_TICKS = cts_pkg::SAFETY_TICKS,
  parameter int unsigned WDOG_TICKS   = cts_pkg::WDOG_TICKS,
  parameter int unsigned DEGL_TICKS   = cts_pkg::DEGLITCH_TICKS,
  parameter int unsigned DET_TICKS    = cts_pkg::DETECT_TICKS,
  parameter int unsigned EOC_TICKS    = cts_pkg::EOC_TICKS,
  parameter bit          HAS_ROLE_PIN = 1'b1
) (
  input  wire logic       clk,              // 125 MHz
  input  wire logic       srst,             // Sync reset, power-on
  input  wire logic       adapter_good,     // Async level
  input  wire logic       battery_good,     // Async level
  input  wire logic       host_role_pin,    // Async level
  input  wire logic       bat_below_short,  // Async comparator
  input  wire logic       bat_below_lowv,   // Async comparator
  input  wire logic       bat_above_rech,   // Async comparator
  input  wire logic       term_current,     // Async comparator
  input  wire logic       lss_above_100ma,  // Async comparator
  input  wire logic       temp_above_reg,   // Async comparator
  input  wire logic       temp_shutdown,    // Async, hysteresis in analog
  input  wire logic       host_write,       // Pulse: any host write
  input  wire logic       wr_timer_restart, // Pulse: restart bit written 1
  input  wire logic       wr_reset,         // Pulse: reset bit written 1
  input  wire logic       wr_ctrl,          // Pulse: control fields written
  input  wire logic       charge_disable_n_wr, // Charge-enable bit value (0 = on)
  input  wire logic       term_enable_wr,   // Termination enable value
  input  wire logic [1:0] ilim_wr,          // Programmed current limit
  input  wire logic [5:0] vreg_wr,          // Programmed regulation code
  input  wire logic       status_read,      // Pulse: host read status
  input  wire logic       por_keep_prog,    // Watchdog alive before POR
  output logic            host_mode,        // 1 = 32-second mode
  output logic            timer_restart_bit,// Self-clearing readback
  output logic            reset_bit,        // Self-clearing readback
  output logic [1:0]      status_state_field, // Reported state
  output logic [2:0]      fault_code,       // Reported fault
  output logic            fault_pulse,      // 128 us interrupt pulse
  output logic            hiz,              // High impedance request
  output logic            pwm_enable,       // Converter on
  output logic            low_side_sync,    // Low-side switch synchronous
  output logic [2:0]      current_mode,     // 0 off 1 short 2 fast 3 taper 4 detect
  output logic            thermal_taper,    // Fold back current
  output logic            detect_sink,      // Discharge current on
  output logic [1:0]      ilim_code,        // Active input limit
  output logic [5:0]      vreg_code,        // Active regulation code
  output logic            term_enable       // Active termination enable
);
  localparam int unsigned NS = 10;
  // Two-flop synchronisers for all asynchronous levels
  logic [NS-1:0] async_in, s1_q, s2_q;
  assign async_in = {adapter_good, battery_good, host_role_pin, bat_below_short, bat_below_lowv,
                     bat_above_rech, term_current, lss_above_100ma, temp_above_reg, temp_shutdown};
  always_ff @(posedge clk)
  begin
    s1_q <= async_in;
    s2_q <= s1_q;
  end
  logic ad_ok, bat_ok, role, below_short, below_lowv, above_rech, term_i, lss_hi, t_reg, t_sd;
  assign {ad_ok, bat_ok, role, below_short, below_lowv, above_rech, term_i, lss_hi, t_reg, t_sd} = s2_q;

  // Shared 1 us time base
  logic [7:0] pre_q, pre_d;
  logic       tick;
  always_comb
    pre_d = (pre_q == 8'(cts_pkg::TICK_CYC - 1)) ? 8'h00 : pre_q + 8'h01;
  always_ff @(posedge clk)
  begin
    if (srst)
      pre_q <= 8'h00;
    else
      pre_q <= pre_d;
  end
  assign tick = (pre_q == 8'(cts_pkg::TICK_CYC - 1)); // [RULE21]

  // Mode, configuration, status state
  logic       mode_q, mode_d, prog_q, prog_d, tr_q, tr_d, rb_q, rb_d;
  logic       ce_n_q, ce_n_d, te_q, te_d, flt_q, flt_d, held_q, held_d;
  logic [1:0] il_q, il_d, st_q, st_d;
  logic [5:0] vr_q, vr_d;
  logic [2:0] fc_q, fc_d;
  logic       por_q, por_d, start_q, start_d;
  logic       saf_exp, wd_exp, dg_exp, det_exp, eoc_exp, pl_exp;
  cts_pkg::cts_phase_type ph_q, ph_d;
  logic       ok, pulse_q, pulse_d, new_cycle;

  assign ok = ad_ok && bat_ok && !flt_q;
  assign new_cycle = (ph_q == cts_pkg::PH_DONE && !above_rech)            // [RULE16]
                   || start_q || (wr_ctrl && charge_disable_n_wr != ce_n_q) || rb_q;

  always_comb
  begin
    mode_d = mode_q;
    prog_d = prog_q;
    tr_d   = 1'b0;                                  // [RULE3]
    rb_d   = 1'b0;                                  // [RULE20]
    ce_n_d = ce_n_q;
    te_d   = te_q;
    il_d   = il_q;
    vr_d   = vr_q;
    flt_d  = flt_q;
    held_d = held_q && !status_read;                // [RULE6]
    st_d   = st_q;
    fc_d   = fc_q;
    por_d  = 1'b0;
    start_d = por_q && below_lowv;                  // [RULE16]
    if (por_q)
      mode_d = por_keep_prog;                       // [RULE7]
    if (host_write && !mode_q)
      mode_d = 1'b1;                                // [RULE1] [RULE2]
    if (host_write)
      prog_d = 1'b1;
    if (wr_timer_restart)
      tr_d = 1'b1;                                  // [RULE3]
    if (wr_ctrl)
    begin
      ce_n_d = charge_disable_n_wr;
      te_d   = term_enable_wr;
      il_d   = ilim_wr;
      vr_d   = (vreg_wr > cts_pkg::VREG_MAX) ? cts_pkg::VREG_MAX : vreg_wr;
    end
    if (wr_reset)
      rb_d = 1'b1;
    if (rb_q || (mode_q && wd_exp && !t_sd))
    begin
      ce_n_d = 1'b0;                                // [RULE20]
      te_d   = 1'b1;
      il_d   = cts_pkg::ILIM_100MA;
      vr_d   = cts_pkg::VREG_DEFAULT;
      prog_d = 1'b0;
    end
    if (mode_q && wd_exp && !t_sd)
      mode_d = 1'b0;                                // [RULE4]
    if (!mode_q && saf_exp && ok)
      flt_d = 1'b1;                                 // [RULE5]
    if (!held_q)
    begin
      if (flt_q)
      begin
        st_d = cts_pkg::STATE_FAULT;
        fc_d = cts_pkg::FAULT_TIMER;
        held_d = 1'b1;
      end
      else if (ph_q == cts_pkg::PH_DONE && eoc_exp)
        st_d = cts_pkg::STATE_DONE;                 // [RULE14]
      else if (ph_q != cts_pkg::PH_IDLE && ph_q != cts_pkg::PH_DONE)
        st_d = cts_pkg::STATE_CHARGING;
      else
        st_d = cts_pkg::STATE_READY;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_q <= 1'b0;
      prog_q <= 1'b0;
      tr_q   <= 1'b0;
      rb_q   <= 1'b0;
      ce_n_q <= 1'b0;
      te_q   <= 1'b1;
      il_q   <= cts_pkg::ILIM_100MA;
      vr_q   <= cts_pkg::VREG_DEFAULT;
      flt_q  <= 1'b0;                              // [RULE6]
      held_q <= 1'b0;
      st_q   <= cts_pkg::STATE_READY;
      fc_q   <= cts_pkg::FAULT_NONE;
      por_q  <= 1'b1;
      start_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      prog_q <= prog_d;
      tr_q   <= tr_d;
      rb_q   <= rb_d;
      ce_n_q <= ce_n_d;
      te_q   <= te_d;
      il_q   <= il_d;
      vr_q   <= vr_d;
      flt_q  <= flt_d;
      held_q <= held_d;
      st_q   <= st_d;
      fc_q   <= fc_d;
      por_q  <= por_d;
      start_q <= start_d;
    end
  end

  // Charge phase sequencer
  logic run_ok;
  assign run_ok = ok && !ce_n_q && !t_sd && !(!mode_q && !below_lowv); // [RULE8] [RULE18] [RULE19]
  always_comb
  begin
    ph_d = ph_q;
    if (!run_ok)
      ph_d = (ph_q == cts_pkg::PH_DONE) ? cts_pkg::PH_DONE : cts_pkg::PH_IDLE;
    if (run_ok || new_cycle)
    begin
      case (ph_q)
        cts_pkg::PH_IDLE:   ph_d = run_ok ? cts_pkg::PH_SHORT : cts_pkg::PH_IDLE;
        cts_pkg::PH_SHORT:  ph_d = below_short ? cts_pkg::PH_SHORT : cts_pkg::PH_FAST; // [RULE11]
        cts_pkg::PH_FAST:   ph_d = below_short ? cts_pkg::PH_SHORT
                                 : (above_rech ? cts_pkg::PH_TAPER : cts_pkg::PH_FAST);
        cts_pkg::PH_TAPER:  ph_d = (!above_rech) ? cts_pkg::PH_FAST
                                 : ((mode_q && te_q && dg_exp && term_i) ? cts_pkg::PH_DETECT
                                    : cts_pkg::PH_TAPER);                // [RULE13] [RULE15]
        cts_pkg::PH_DETECT: ph_d = !det_exp ? cts_pkg::PH_DETECT
                                 : (above_rech ? cts_pkg::PH_DONE : cts_pkg::PH_FAST); // [RULE14]
        cts_pkg::PH_DONE:   ph_d = new_cycle ? cts_pkg::PH_IDLE : cts_pkg::PH_DONE;
        default:            ph_d = cts_pkg::PH_IDLE;
      endcase
    end
    if (new_cycle && ph_q != cts_pkg::PH_DONE)
      ph_d = cts_pkg::PH_IDLE;                     // [RULE16]
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      ph_q <= cts_pkg::PH_IDLE;
    else
      ph_q <= ph_d;
  end

  // Intervals, all from the one tick; shutdown freezes all but the fault pulse interval
  cts_interval #(.W(cts_pkg::TW)) u_safety (.clk(clk), .srst(srst), .tick(tick),
    .run(!mode_q && ok), .freeze(t_sd), .restart(host_write),                 // [RULE1] [RULE18]
    .limit(cts_pkg::TW'(SAFETY_TICKS)), .expired(saf_exp));
  cts_interval #(.W(cts_pkg::TW)) u_wdog (.clk(clk), .srst(srst), .tick(tick),
    .run(mode_q), .freeze(t_sd), .restart(tr_q),                              // [RULE2] [RULE3]
    .limit(cts_pkg::TW'(WDOG_TICKS)), .expired(wd_exp));
  cts_interval #(.W(cts_pkg::TW)) u_degl (.clk(clk), .srst(srst), .tick(tick),
    .run(ph_q == cts_pkg::PH_TAPER && above_rech), .freeze(t_sd), .restart(1'b0),
    .limit(cts_pkg::TW'(DEGL_TICKS)), .expired(dg_exp));                      // [RULE13]
  cts_interval #(.W(cts_pkg::TW)) u_det (.clk(clk), .srst(srst), .tick(tick),
    .run(ph_q == cts_pkg::PH_DETECT), .freeze(t_sd), .restart(1'b0),
    .limit(cts_pkg::TW'(DET_TICKS)), .expired(det_exp));                      // [RULE13]
  cts_interval #(.W(cts_pkg::TW)) u_eoc (.clk(clk), .srst(srst), .tick(tick),
    .run(ph_q == cts_pkg::PH_DONE), .freeze(t_sd), .restart(1'b0),
    .limit(cts_pkg::TW'(EOC_TICKS)), .expired(eoc_exp));                      // [RULE14]
  cts_interval #(.W(cts_pkg::TW)) u_pulse (.clk(clk), .srst(srst), .tick(tick),
    .run(pulse_q), .freeze(1'b0), .restart(1'b0),
    .limit(cts_pkg::TW'(cts_pkg::PULSE_TICKS)), .expired(pl_exp));            // [RULE5]

  // Fault pulse and registered outputs
  always_comb
    pulse_d = (pulse_q && !pl_exp) || (!flt_q && flt_d);                      // [RULE5]
  logic [2:0] cm_d;
  logic [1:0] il_act;
  always_comb
  begin
    case (ph_q)
      cts_pkg::PH_SHORT:  cm_d = 3'h1;
      cts_pkg::PH_FAST:   cm_d = 3'h2;
      cts_pkg::PH_TAPER:  cm_d = 3'h3;
      cts_pkg::PH_DETECT: cm_d = 3'h4;
      default:            cm_d = 3'h0;
    endcase
    if (mode_q && prog_q)
      il_act = il_q;                                                          // [RULE9]
    else if (HAS_ROLE_PIN)
      il_act = role ? cts_pkg::ILIM_500MA : cts_pkg::ILIM_100MA;
    else
      il_act = cts_pkg::ILIM_500MA;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pulse_q <= 1'b0;
      host_mode <= 1'b0;
      hiz <= 1'b1;
      pwm_enable <= 1'b0;
      low_side_sync <= 1'b0;
      current_mode <= 3'h0;
      thermal_taper <= 1'b0;
      detect_sink <= 1'b0;
      ilim_code <= cts_pkg::ILIM_100MA;
      vreg_code <= cts_pkg::VREG_DEFAULT;
      term_enable <= 1'b1;
    end
    else
    begin
      pulse_q <= pulse_d;
      host_mode <= mode_q;
      hiz <= !mode_q && !below_lowv;                                          // [RULE8]
      pwm_enable <= cm_d != 3'h0 && cm_d != 3'h4 && !t_sd;                    // [RULE18]
      low_side_sync <= lss_hi && cm_d != 3'h0 && cm_d != 3'h4 && !t_sd;       // [RULE10]
      current_mode <= cm_d;                                                   // [RULE11]
      thermal_taper <= t_reg;                                                 // [RULE17]
      detect_sink <= ph_q == cts_pkg::PH_DETECT;                              // [RULE13]
      ilim_code <= il_act;
      vreg_code <= (mode_q && prog_q) ? vr_q : cts_pkg::VREG_DEFAULT;         // [RULE12]
      term_enable <= te_q;
    end
  end
  assign timer_restart_bit = tr_q;
  assign reset_bit = rb_q;
  assign status_state_field = st_q;
  assign fault_code = fc_q;
  assign fault_pulse = pulse_q;

  a_no_term_off: assert property (@(posedge clk) disable iff (srst)
    !te_q |=> ph_q != cts_pkg::PH_DETECT || $past(ph_q) == cts_pkg::PH_DETECT) else $error("detect without enable"); // [RULE15]
  a_write_hostmode: assert property (@(posedge clk) disable iff (srst)
    (host_write && !mode_q && !por_q) |=> mode_q) else $error("host write kept safety mode"); // [RULE1]
  a_restart_clear: assert property (@(posedge clk) disable iff (srst)
    tr_q |=> !tr_q || $past(wr_timer_restart)) else $error("restart bit stuck"); // [RULE3]
  a_wdog_default: assert property (@(posedge clk) disable iff (srst)
    (mode_q && wd_exp && !t_sd && !por_q) |=> !mode_q && vr_q == cts_pkg::VREG_DEFAULT) else $error("watchdog expiry"); // [RULE4]
  a_fault_pulse: assert property (@(posedge clk) disable iff (srst)
    $rose(flt_q) |-> pulse_q) else $error("no fault pulse"); // [RULE5]
  a_fault_sticky: assert property (@(posedge clk) disable iff (srst)
    flt_q |=> flt_q) else $error("fault cleared without reset"); // [RULE6]
  a_status_held: assert property (@(posedge clk) disable iff (srst)
    (held_q && !status_read) |=> $stable(st_q)) else $error("status moved before read"); // [RULE6]
  a_shutdown_pwm: assert property (@(posedge clk) disable iff (srst)
    t_sd |=> !pwm_enable) else $error("pwm on in shutdown"); // [RULE18]
  a_reset_clear: assert property (@(posedge clk) disable iff (srst)
    rb_q |=> ce_n_q == 1'b0 && il_q == cts_pkg::ILIM_100MA) else $error("reset defaults"); // [RULE20]
  c_detect: cover property (@(posedge clk) ph_q == cts_pkg::PH_DETECT);
  c_done: cover property (@(posedge clk) st_q == cts_pkg::STATE_DONE);
  c_fault: cover property (@(posedge clk) $rose(pulse_q));
  c_wdog: cover property (@(posedge clk) mode_q && wd_exp);
endmodule // cts_supervisor
`default_nettype wire

// ### bench/cts_host_model.sv
// Host processor model: issues write and read strobes to the supervisor.
// Assumes strobes are sampled on rising clk; it drives 1 ns after the edge.
`timescale 1ns/100ps
`default_nettype none
module cts_host_model (
  input  wire logic       clk,                 // System clock
  output logic            host_write,          // Any write
  output logic            wr_timer_restart,    // Restart bit written 1
  output logic            wr_reset,            // Reset bit written 1
  output logic            wr_ctrl,             // Control fields written
  output logic            charge_disable_n_wr, // 0 = charge on
  output logic            term_enable_wr,      // Termination enable
  output logic [1:0]      ilim_wr,             // Limit code
  output logic [5:0]      vreg_wr,             // Regulation code
  output logic            status_read          // Status read
);
  initial
  begin
    {status_read, host_write, wr_timer_restart, wr_reset, wr_ctrl} = 5'h00;
    {charge_disable_n_wr, term_enable_wr, ilim_wr, vreg_wr} = 10'h102;
  end
  // One-cycle strobe; data stands until the next access
  task automatic op(input logic [4:0] s, input logic [9:0] v);
    @(posedge clk);
    #1;
    {charge_disable_n_wr, term_enable_wr, ilim_wr, vreg_wr} = v;
    {status_read, host_write, wr_timer_restart, wr_reset, wr_ctrl} = s;
    @(posedge clk);
    #1;
    {status_read, host_write, wr_timer_restart, wr_reset, wr_ctrl} = 5'h00;
  endtask
endmodule // cts_host_model
`default_nettype wire

// ### bench/cts_supervisor_bench.sv
// Self-checking bench for the supervisor with shortened intervals.
// Assumes 1 tick = 125 cycles; notes go through a queue to a checking process.
`timescale 1ns/100ps
`default_nettype none
module cts_supervisor_bench;
  localparam int TK = 125;
  localparam int WD = 30;
  localparam logic [4:0] WC = 5'b01001;
  localparam logic [4:0] WT = 5'b01100;
  localparam logic [4:0] WR = 5'b01010;
  localparam logic [9:0] CFG = {1'b0, 1'b1, 2'h1, 6'h3f};
  typedef struct {string nm; int sel; logic [15:0] e;} cts_note_type;
  cts_note_type q[$];
  event look;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int plen;
  bit sr;
  logic [3:0] h = 4'h0;
  logic [31:0] rnd = 32'h40363c8a;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic adapter_good, battery_good, host_role_pin, bat_below_short, bat_below_lowv, bat_above_rech;
  logic term_current, lss_above_100ma, temp_above_reg, temp_shutdown, por_keep_prog, status_read;
  logic host_write, wr_timer_restart, wr_reset, wr_ctrl, charge_disable_n_wr, term_enable_wr;
  logic [1:0] ilim_wr, status_state_field, ilim_code;
  logic [5:0] vreg_wr, vreg_code;
  logic [2:0] fault_code, current_mode;
  logic host_mode, timer_restart_bit, reset_bit, fault_pulse, hiz, pwm_enable, low_side_sync;
  logic thermal_taper, detect_sink, term_enable;

  cts_supervisor #(.SAFETY_TICKS(50), .WDOG_TICKS(WD), .DEGL_TICKS(5), .DET_TICKS(8),
    .EOC_TICKS(4), .HAS_ROLE_PIN(1'b1)) i_cts_supervisor (.clk, .srst, .adapter_good,
    .battery_good, .host_role_pin, .bat_below_short, .bat_below_lowv, .bat_above_rech,
    .term_current, .lss_above_100ma, .temp_above_reg, .temp_shutdown, .host_write,
    .wr_timer_restart, .wr_reset, .wr_ctrl, .charge_disable_n_wr, .term_enable_wr, .ilim_wr,
    .vreg_wr, .status_read, .por_keep_prog, .host_mode, .timer_restart_bit, .reset_bit,
    .status_state_field, .fault_code, .fault_pulse, .hiz, .pwm_enable, .low_side_sync,
    .current_mode, .thermal_taper, .detect_sink, .ilim_code, .vreg_code, .term_enable);
  cts_host_model i_cts_host_model (.clk, .host_write, .wr_timer_restart, .wr_reset, .wr_ctrl,
    .charge_disable_n_wr, .term_enable_wr, .ilim_wr, .vreg_wr, .status_read);

  initial
    forever #4 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] pick(input int sel);
    case (sel)
      0: return 16'(host_mode);
      1: return 16'(status_state_field);
      2: return 16'(fault_code);
      3: return 16'(ilim_code);
      4: return 16'(vreg_code);
      5: return 16'(pwm_enable);
      6: return 16'(timer_restart_bit);
      7: return 16'(term_enable);
      8: return 16'(detect_sink);
      9: return 16'(fault_pulse);
      10: return 16'(hiz);
      11: return 16'(plen >= 127 * TK && plen <= 129 * TK);
      12: return 16'(reset_bit);
      13: return 16'(thermal_taper);
      14: return 16'(current_mode);
      15: return 16'(low_side_sync);
      default: return 16'hffff;
    endcase
  endfunction

  task automatic results();
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Waits a bounded time for the value, then leaves a note either way
  task automatic see(input string nm, input int sel, input logic [15:0] e, input int n);
    for (int i = 0; i < n && pick(sel) !== e; i++)
      @(negedge clk);
    q.push_back('{nm, sel, e});
    -> look;
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  always @(look)
    while (q.size() > 0)
    begin
      cts_note_type n;
      n = q.pop_front();
      chk(n.nm, pick(n.sel), n.e);
    end

  // Comparator noise; outputs follow three edges later
  always @(posedge clk)
  begin
    sr = srst;
    #1;
    q.push_back('{"taper", 13, 16'(!sr && h[2])});
    q.push_back('{"lss", 15, 16'(h[3] && pwm_enable)});
    -> look;
    h = {h[1:0], lss_above_100ma, temp_above_reg};
    rnd = lfsr(rnd);
    lss_above_100ma = rnd[0];
    temp_above_reg = rnd[7];
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    {adapter_good, battery_good, host_role_pin, bat_below_short, bat_below_lowv} = 5'b11100;
    {bat_above_rech, term_current, lss_above_100ma, temp_above_reg, temp_shutdown, por_keep_prog} = 6'h00;
    go(5);
    srst = 1'b0;
    go(2);
    see("mode", 0, 16'h0, 0);
    see("vreg", 4, 16'(cts_pkg::VREG_DEFAULT), 0);
    see("ilim", 3, 16'(cts_pkg::ILIM_500MA), 4);
    see("hiz", 10, 16'h1, 4);
    go(1);
    host_role_pin = 1'b0;
    bat_below_lowv = 1'b1;
    see("ilim", 3, 16'(cts_pkg::ILIM_100MA), 6);
    see("hiz", 10, 16'h0, 6);
    see("state", 1, 16'(cts_pkg::STATE_FAULT), 52 * TK);
    see("fault", 2, 16'(cts_pkg::FAULT_TIMER), 4);
    see("pulse", 9, 16'h1, 4);
    plen = 0;
    while (fault_pulse === 1'b1 && plen < 20000)
    begin
      @(negedge clk);
      plen++;
    end
    see("plen", 11, 16'h1, 0);
    see("pwm", 5, 16'h0, 0);
    i_cts_host_model.op(5'b10000, CFG);
    go(4);
    see("held", 1, 16'(cts_pkg::STATE_FAULT), 0);
    srst = 1'b1;
    por_keep_prog = 1'b1;
    go(2);
    srst = 1'b0;
    go(2);
    see("keep", 0, 16'h1, 0);
    see("clear", 2, 16'(cts_pkg::FAULT_NONE), 0);
    i_cts_host_model.op(WC, CFG);
    see("mode", 0, 16'h1, 4);
    see("ilim", 3, 16'(cts_pkg::ILIM_500MA), 4);
    see("vreg", 4, 16'(cts_pkg::VREG_MAX), 4);
    i_cts_host_model.op(WT, CFG);
    see("rbit", 6, 16'h1, 3);
    see("rbit", 6, 16'h0, 2);
    repeat (3)
    begin
      go(20 * TK);
      i_cts_host_model.op(WT, CFG);
    end
    go(WD * TK - 2 * TK);
    see("alive", 0, 16'h1, 0);
    see("expire", 0, 16'h0, 4 * TK);
    see("dflt", 4, 16'(cts_pkg::VREG_DEFAULT), 4);
    see("dflt", 3, 16'(cts_pkg::ILIM_100MA), 4);
    i_cts_host_model.op(WC, CFG);
    temp_shutdown = 1'b1;
    see("pwm", 5, 16'h0, 6);
    go(40 * TK);
    see("frozen", 0, 16'h1, 0);
    temp_shutdown = 1'b0;
    see("expire", 0, 16'h0, 32 * TK);
    i_cts_host_model.op(WC, {1'b1, CFG[8:0]});
    see("pwm", 5, 16'h0, 6);
    i_cts_host_model.op(WC, CFG);
    see("pwm", 5, 16'h1, 8);
    see("short", 14, 16'h1, 0);
    see("cmode", 14, 16'h2, 4);
    go(1);
    bat_above_rech = 1'b1;
    term_current = 1'b1;
    see("sink", 8, 16'h1, 7 * TK);
    see("cmode", 14, 16'h4, 0);
    see("pwm", 5, 16'h0, 0);
    see("done", 1, 16'(cts_pkg::STATE_DONE), 14 * TK);
    i_cts_host_model.op(WC, {1'b0, 1'b0, 2'h1, 6'h3f});
    bat_above_rech = 1'b0;
    see("term", 7, 16'h0, 4);
    see("again", 1, 16'(cts_pkg::STATE_CHARGING), 20);
    go(1);
    bat_above_rech = 1'b1;
    go(10 * TK);
    see("nosink", 8, 16'h0, 0);
    see("cmode", 14, 16'h3, 0);
    i_cts_host_model.op(WR, CFG);
    see("reset", 12, 16'h1, 3);
    see("reset", 12, 16'h0, 2);
    see("vreg", 4, 16'(cts_pkg::VREG_DEFAULT), 4);
    see("term", 7, 16'h1, 4);
    go(2);
    results();
  end
endmodule // cts_supervisor_bench
`default_nettype wire
